// [core/uhb_host_bus_ctrl.sv]
// host-mode bus control: power fault, IN scheduling, bus signalling, irq masks
`timescale 1ns/10ps
`include "uhb_regs.svh"
module uhb_host_bus_ctrl #(
	parameter int EPW = 4,
	parameter int CEV = 8,
	parameter int ADDR_W = 8,
	parameter int CNT_W = 20,
	parameter int RESET_MIN_CYC = `UHB_N_RESET_MIN,
	parameter int RSM_DEV_MIN_CYC = `UHB_N_RSM_DEV_MIN,
	parameter int RSM_DEV_MAX_CYC = `UHB_N_RSM_DEV_MAX,
	parameter int RSM_HOST_MIN_CYC = `UHB_N_RSM_HOST_MIN
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output uhb_pkg::uhb_resp_type bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output uhb_pkg::uhb_resp_type rresp,
	output logic rvalid,
	input wire logic rready,
	// power fault pin
	input wire logic power_fault_input_n,
	// token request to link
	output logic in_tok_valid,
	input wire logic in_tok_ready,
	output logic [EPW-1:0] in_tok_ep,
	output logic in_tok_status,
	// events and data from link
	input wire logic link_in_valid,
	input wire logic [EPW-1:0] link_in_ep,
	input wire logic [31:0] link_in_data,
	input wire logic link_status_done,
	input wire logic [CEV-2:0] link_ctrl_evt,
	input wire logic link_connected,
	input wire uhb_pkg::uhb_speed_type link_speed,
	// bus signalling
	output logic bus_reset,
	output logic bus_resume,
	output logic bus_resume_end,
	output logic bus_suspend,
	// dma path
	output logic dma_valid,
	output logic [EPW-1:0] dma_ep,
	output logic [31:0] dma_data,
	// interrupt
	output logic irq
);
	import uhb_pkg::*;
	localparam int NEP = 2 ** EPW;

	logic wr_fire, rd_fire;
	logic [31:0] wmask, wd;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	uhb_resp_type bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic host_q, host_d, pflt_en_q, pflt_en_d, reset_q, reset_d;
	logic resume_q, resume_d, suspend_q, suspend_d, stpend_q, stpend_d;
	logic rsm_end_q, rsm_end_d, pf_s1_q, pf_s2_q, pf_evt;
	logic [NEP-1:0] in_pend_q, in_pend_d, in_set, in_clr, in_hs, eevt;
	logic [NEP-1:0] emask_q, emask_d, estat_q, estat_d;
	logic [CEV-1:0] cmask_q, cmask_d, cstat_q, cstat_d, cevt;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	uhb_speed_type speed_q, speed_d;
	logic [31:0] epdata_q, epdata_d;
	logic dma_valid_q, dma_valid_d;
	logic [EPW-1:0] dma_ep_q, dma_ep_d, low_ep;
	logic min_met, max_over, wr_ctrl, hold_start;

	function automatic logic wsel(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a == ADDR_W'(off);
	endfunction

	// bus handshakes
	assign wr_fire = awvalid && wvalid && !bvalid_q;
	assign awready = wr_fire;
	assign wready = wr_fire;
	assign rd_fire = arvalid && !rvalid_q;
	assign arready = !rvalid_q;
	assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
	assign wd = wdata & wmask;
	assign wr_ctrl = wr_fire && wsel(awaddr, `UHB_OFF_CTRL);
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

	// bus response and read data
	always_comb begin
		bvalid_d = bvalid_q && !bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (wr_fire) begin
			bvalid_d = 1'b1;
			bresp_d = (awaddr > ADDR_W'(`UHB_OFF_EP_DATA) || awaddr[1:0] != 2'h0)
				? RESP_SLVERR : RESP_OKAY;
		end
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = 32'h0000_0000;
			case (araddr)
				ADDR_W'(`UHB_OFF_CTRL): rdata_d = {26'h0, stpend_q, suspend_q, resume_q,
					reset_q, pflt_en_q, host_q};
				ADDR_W'(`UHB_OFF_IN_REQ): rdata_d = 32'(in_pend_q);
				ADDR_W'(`UHB_OFF_CIEN_SET): rdata_d = 32'(cmask_q);
				ADDR_W'(`UHB_OFF_EIEN_SET): rdata_d = 32'(emask_q);
				ADDR_W'(`UHB_OFF_CSTAT): rdata_d = 32'(cstat_q);
				ADDR_W'(`UHB_OFF_ESTAT): rdata_d = 32'(estat_q);
				ADDR_W'(`UHB_OFF_LINK): rdata_d = {26'h0, max_over, min_met, 2'h0, speed_q};
				ADDR_W'(`UHB_OFF_EP_DATA): rdata_d = epdata_q;
				ADDR_W'(`UHB_OFF_IN_CLR), ADDR_W'(`UHB_OFF_CIEN_CLR),
				ADDR_W'(`UHB_OFF_EIEN_CLR): rdata_d = 32'h0000_0000;
				default: rresp_d = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	// power fault pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pf_s1_q <= 1'b1;
			pf_s2_q <= 1'b1;
		end else begin
			pf_s1_q <= power_fault_input_n;
			pf_s2_q <= pf_s1_q;
		end
	end
	assign pf_evt = pflt_en_q && host_q && !pf_s2_q;
	assign cevt = {link_ctrl_evt, pf_evt};

	// per endpoint request, cancel, handshake and event terms
	always_comb begin
		low_ep = '0;
		for (int i = NEP - 1; i >= 0; i--) begin
			if (in_pend_q[i]) begin
				low_ep = EPW'(i);
			end
		end
	end
	genvar g;
	generate
		for (g = 0; g < NEP; g++) begin : g_ep
			assign in_set[g] = wr_fire && host_q && wsel(awaddr, `UHB_OFF_IN_REQ) && wd[g];
			assign in_clr[g] = wr_fire && wsel(awaddr, `UHB_OFF_IN_CLR) && wd[g];
			assign in_hs[g] = in_tok_valid && in_tok_ready && !in_tok_status
				&& in_tok_ep == EPW'(g);
			assign eevt[g] = (link_in_valid && link_in_ep == EPW'(g))
				|| (g == 0 && link_status_done);
		end
	endgenerate

	// token offer: status phase first, then lowest pending IN endpoint
	assign in_tok_valid = host_q && !reset_q && !suspend_q && (stpend_q || (|in_pend_q));
	assign in_tok_status = stpend_q;
	assign in_tok_ep = stpend_q ? '0 : low_ep;

	assign hold_start = wr_ctrl && ((wd[`UHB_CTRL_RESET] && !reset_q)
		|| (wd[`UHB_CTRL_RESUME] && !resume_q));
	assign min_met = reset_q ? (int'(cnt_q) >= RESET_MIN_CYC)
		: resume_q && (int'(cnt_q) >= (host_q ? RSM_HOST_MIN_CYC : RSM_DEV_MIN_CYC));
	assign max_over = resume_q && !host_q && (int'(cnt_q) > RSM_DEV_MAX_CYC);

	// core control state
	always_comb begin
		host_d = host_q;
		pflt_en_d = pflt_en_q;
		reset_d = reset_q;
		resume_d = resume_q;
		suspend_d = suspend_q;
		cmask_d = cmask_q;
		emask_d = emask_q;
		rsm_end_d = 1'b0;
		if (wr_ctrl && wstrb[0]) begin
			host_d = wd[`UHB_CTRL_HOST];
			pflt_en_d = wd[`UHB_CTRL_PFLT_EN];
			reset_d = wd[`UHB_CTRL_RESET];
			resume_d = wd[`UHB_CTRL_RESUME];
			suspend_d = wd[`UHB_CTRL_SUSPEND] && !wd[`UHB_CTRL_RESUME];
			rsm_end_d = host_q && resume_q && !wd[`UHB_CTRL_RESUME];
		end
		if (wr_fire && wsel(awaddr, `UHB_OFF_CIEN_SET)) cmask_d = cmask_q | wd[CEV-1:0];
		if (wr_fire && wsel(awaddr, `UHB_OFF_CIEN_CLR)) cmask_d = cmask_q & ~wd[CEV-1:0];
		if (wr_fire && wsel(awaddr, `UHB_OFF_EIEN_SET)) emask_d = emask_q | wd[NEP-1:0];
		if (wr_fire && wsel(awaddr, `UHB_OFF_EIEN_CLR)) emask_d = emask_q & ~wd[NEP-1:0];
		// set wins over the read clear
		cstat_d = ((rd_fire && wsel(araddr, `UHB_OFF_CSTAT)) ? '0 : cstat_q) | cevt;
		estat_d = ((rd_fire && wsel(araddr, `UHB_OFF_ESTAT)) ? '0 : estat_q) | eevt;
		in_pend_d = (in_pend_q & ~in_hs & ~in_clr) | in_set;
		stpend_d = (stpend_q && !(in_tok_valid && in_tok_ready))
			|| (wr_ctrl && host_q && wd[`UHB_CTRL_STATUS_REQ]);
		if (hold_start || (!reset_q && !resume_q)) cnt_d = '0;
		else if (cnt_q != '1) cnt_d = cnt_q + 1'b1;
		else cnt_d = cnt_q;
		speed_d = (host_q && link_connected) ? link_speed : SPEED_CODE_UNDEFINED;
		epdata_d = link_in_valid ? link_in_data : epdata_q;
		dma_valid_d = link_in_valid;
		dma_ep_d = link_in_valid ? link_in_ep : dma_ep_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_q <= 1'b0;
			pflt_en_q <= 1'b0;
			reset_q <= 1'b0;
			resume_q <= 1'b0;
			suspend_q <= 1'b0;
			rsm_end_q <= 1'b0;
			stpend_q <= 1'b0;
			cmask_q <= CEV'(`UHB_MASK_RST);
			emask_q <= NEP'(`UHB_MASK_RST);
			cstat_q <= '0;
			estat_q <= '0;
			in_pend_q <= '0;
			cnt_q <= '0;
			speed_q <= SPEED_CODE_UNDEFINED;
			epdata_q <= 32'h0000_0000;
			dma_valid_q <= 1'b0;
			dma_ep_q <= '0;
		end else begin
			host_q <= host_d;
			pflt_en_q <= pflt_en_d;
			reset_q <= reset_d;
			resume_q <= resume_d;
			suspend_q <= suspend_d;
			rsm_end_q <= rsm_end_d;
			stpend_q <= stpend_d;
			cmask_q <= cmask_d;
			emask_q <= emask_d;
			cstat_q <= cstat_d;
			estat_q <= estat_d;
			in_pend_q <= in_pend_d;
			cnt_q <= cnt_d;
			speed_q <= speed_d;
			epdata_q <= epdata_d;
			dma_valid_q <= dma_valid_d;
			dma_ep_q <= dma_ep_d;
		end
	end

	assign bus_reset = host_q && reset_q;
	assign bus_resume = resume_q;
	assign bus_resume_end = rsm_end_q;
	assign bus_suspend = host_q && suspend_q;
	assign dma_valid = dma_valid_q;
	assign dma_ep = dma_ep_q;
	assign dma_data = epdata_q;
	assign irq = (|(cstat_q & cmask_q)) || (|(estat_q & emask_q));

	AST_PF_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
		(!pflt_en_q && !cstat_q[`UHB_CIRQ_PFAULT]) |=> !cstat_q[`UHB_CIRQ_PFAULT])
		else $error("power fault flagged while detection off");
	AST_PF_ON: assert property (@(posedge aclk) disable iff (!aresetn)
		(pflt_en_q && host_q && !pf_s2_q) |=> cstat_q[`UHB_CIRQ_PFAULT])
		else $error("power fault missed");
	AST_IN_SCHED: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_set[1] && !in_clr[1]) |=> in_pend_q[1] && in_tok_valid || suspend_q || reset_q)
		else $error("IN request not scheduled");
	AST_IN_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
		link_in_valid |=> dma_valid && dma_data == $past(link_in_data) && dma_ep == $past(link_in_ep))
		else $error("IN data not presented");
	AST_IN_CANCEL: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_clr[2] && !in_set[2]) |=> !in_pend_q[2])
		else $error("IN cancel ignored");
	AST_STATUS_EP0: assert property (@(posedge aclk) disable iff (!aresetn)
		(in_tok_valid && in_tok_status) |-> in_tok_ep == '0)
		else $error("status token off endpoint zero");
	AST_STATUS_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
		link_status_done |=> estat_q[0] ##1 (estat_q[0] || $past(rd_fire)))
		else $error("status completion not flagged");
	AST_RSM_END: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_ctrl && wstrb[0] && host_q && resume_q && !wdata[`UHB_CTRL_RESUME])
		|=> bus_resume_end && !bus_resume ##1 !bus_resume_end)
		else $error("resume completion missing");
	AST_SPEED_UNDEF: assert property (@(posedge aclk) disable iff (!aresetn)
		!host_q |=> speed_q == SPEED_CODE_UNDEFINED)
		else $error("speed reported outside host mode");
	AST_CMASK_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && wsel(awaddr, `UHB_OFF_CIEN_SET)) |=>
		cmask_q == ($past(cmask_q) | $past(wd[CEV-1:0])) && $stable(emask_q))
		else $error("control unmask wrong");
	AST_EMASK_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && wsel(awaddr, `UHB_OFF_EIEN_CLR)) |=>
		emask_q == ($past(emask_q) & ~$past(wd[NEP-1:0])) && $stable(cmask_q))
		else $error("endpoint mask wrong");
	AST_CSTAT_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_fire && wsel(araddr, `UHB_OFF_CSTAT)) |=> rdata == 32'($past(cstat_q))
		&& cstat_q == $past(cevt))
		else $error("control status read-clear wrong");
	AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		(cstat_q[`UHB_CIRQ_PFAULT] && cmask_q[`UHB_CIRQ_PFAULT]) |-> irq)
		else $error("irq not raised");
endmodule

// [core/uhb_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef UHB_REGS_SVH
`define UHB_REGS_SVH

`define UHB_OFF_CTRL 8'h00
`define UHB_OFF_IN_REQ 8'h04
`define UHB_OFF_IN_CLR 8'h08
`define UHB_OFF_CIEN_SET 8'h0C
`define UHB_OFF_CIEN_CLR 8'h10
`define UHB_OFF_EIEN_SET 8'h14
`define UHB_OFF_EIEN_CLR 8'h18
`define UHB_OFF_CSTAT 8'h1C
`define UHB_OFF_ESTAT 8'h20
`define UHB_OFF_LINK 8'h24
`define UHB_OFF_EP_DATA 8'h28

`define UHB_CTRL_HOST 0
`define UHB_CTRL_PFLT_EN 1
`define UHB_CTRL_RESET 2
`define UHB_CTRL_RESUME 3
`define UHB_CTRL_SUSPEND 4
`define UHB_CTRL_STATUS_REQ 5
`define UHB_LINK_MIN_MET 4
`define UHB_LINK_MAX_OVER 5
`define UHB_CIRQ_PFAULT 0

`define UHB_MASK_RST 32'h0000_0000

`define UHB_CLK_MHZ 40
`define UHB_T_RESET_MIN_US 20000
`define UHB_T_RSM_DEV_MIN_US 10000
`define UHB_T_RSM_DEV_MAX_US 15000
`define UHB_T_RSM_HOST_MIN_US 20000
`define UHB_N_RESET_MIN (`UHB_T_RESET_MIN_US * `UHB_CLK_MHZ)
`define UHB_N_RSM_DEV_MIN (`UHB_T_RSM_DEV_MIN_US * `UHB_CLK_MHZ)
`define UHB_N_RSM_DEV_MAX (`UHB_T_RSM_DEV_MAX_US * `UHB_CLK_MHZ)
`define UHB_N_RSM_HOST_MIN (`UHB_T_RSM_HOST_MIN_US * `UHB_CLK_MHZ)

`endif

// [core/uhb_pkg.sv]
// types shared by the host bus control block
package uhb_pkg;
	typedef enum logic [1:0] {
		SPEED_CODE_UNDEFINED = 2'h0,
		SPEED_LOW = 2'h1,
		SPEED_FULL = 2'h2,
		SPEED_HIGH = 2'h3
	} uhb_speed_type;
	typedef enum logic [1:0] {
		RESP_OKAY = 2'h0,
		RESP_SLVERR = 2'h2
	} uhb_resp_type;
endpackage

// [testbench/uhb_dev_model.sv]
// attached device model: takes tokens after a lag and answers them
`timescale 1ns/10ps
module uhb_dev_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// token side
	input wire logic in_tok_valid,
	input wire logic [3:0] in_tok_ep,
	input wire logic in_tok_status,
	output logic in_tok_ready,
	// bench controls
	input wire logic [7:0] lag,
	input wire logic [31:0] seed,
	// answer side
	output logic link_in_valid,
	output logic [3:0] link_in_ep,
	output logic [31:0] link_in_data,
	output logic link_status_done
);
	logic [7:0] cnt_q;
	logic [31:0] last_q;
	assign in_tok_ready = in_tok_valid && cnt_q >= lag;
	always_ff @(posedge aclk) begin
		link_in_valid <= 1'h0;
		link_status_done <= 1'h0;
		// released data lines show no stale word
		link_in_data <= ~last_q;
		if (!aresetn) begin
			cnt_q <= 8'h00;
			last_q <= 32'h0;
			link_in_ep <= 4'h0;
		end else if (in_tok_valid && in_tok_ready) begin
			cnt_q <= 8'h00;
			link_status_done <= in_tok_status;
			link_in_valid <= !in_tok_status;
			link_in_ep <= in_tok_ep;
			link_in_data <= {seed[31:4], in_tok_ep};
			last_q <= {seed[31:4], in_tok_ep};
		end else if (in_tok_valid) begin
			cnt_q <= cnt_q + 8'h01;
		end else begin
			cnt_q <= 8'h00;
		end
	end
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the host bus control block
`timescale 1ns/10ps
`include "uhb_regs.svh"
module tb_top;
	import uhb_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, power_fault_input_n = 1'h1, link_connected = 1'h1;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, lag = 8'h00, cm = 8'h00;
	logic [31:0] wdata = 32'h0, seed = 32'h0, rv, rnd = 32'hA177;
	logic [6:0] link_ctrl_evt = 7'h00;
	uhb_speed_type link_speed = SPEED_CODE_UNDEFINED;
	uhb_resp_type bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, irq, seen_st;
	logic [31:0] rdata, link_in_data, dma_data, dma_w;
	logic in_tok_valid, in_tok_ready, in_tok_status, link_in_valid, link_status_done;
	logic bus_reset, bus_resume, bus_resume_end, bus_suspend, dma_valid;
	logic [3:0] in_tok_ep, link_in_ep, dma_ep, dma_e, seen_ep, em = 4'h0, wstrb = 4'hF;
	logic [1:0] resp;
	int fail_count = 0, check_count = 0, dma_n = 0, rend_n = 0, n, k;

	uhb_host_bus_ctrl #(.RESET_MIN_CYC(20), .RSM_DEV_MIN_CYC(10), .RSM_DEV_MAX_CYC(15),
		.RSM_HOST_MIN_CYC(20)) uhb_host_bus_ctrl_inst (.aclk, .aresetn, .awaddr,
		.awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .power_fault_input_n, .in_tok_valid, .in_tok_ready, .in_tok_ep,
		.in_tok_status, .link_in_valid, .link_in_ep, .link_in_data, .link_status_done,
		.link_ctrl_evt, .link_connected, .link_speed, .bus_reset, .bus_resume,
		.bus_resume_end, .bus_suspend, .dma_valid, .dma_ep, .dma_data, .irq);
	uhb_dev_model uhb_dev_model_inst (.aclk, .aresetn, .in_tok_valid, .in_tok_ep,
		.in_tok_status, .in_tok_ready, .lag, .seed, .link_in_valid, .link_in_ep,
		.link_in_data, .link_status_done);

	always #12.5 aclk = ~aclk;
	// records of what crossed the ports
	always @(posedge aclk) begin
		if (in_tok_valid && in_tok_ready) begin
			seen_ep <= in_tok_ep;
			seen_st <= in_tok_status;
		end
		if (dma_valid) begin
			dma_n <= dma_n + 1;
			dma_w <= dma_data;
			dma_e <= dma_ep;
		end
		if (bus_resume_end) rend_n <= rend_n + 1;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [31:0] exp_data(input logic [3:0] ep);
		return {seed[31:4], ep};
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tmo(input int c);
		if (c >= 100) begin
			fail_count++;
			$display("MISMATCH wait exp done got timeout");
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int c;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		c = 0;
		do begin @(posedge aclk); c++; end while ((awready & wready) !== 1'h1 && c < 100);
		tmo(c);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		c = 0;
		do begin @(posedge aclk); c++; end while (bvalid !== 1'h1 && c < 100);
		tmo(c);
		resp = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		int c;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		c = 0;
		do begin @(posedge aclk); c++; end while (arready !== 1'h1 && c < 100);
		tmo(c);
		arvalid <= 1'h0;
		c = 0;
		do begin @(posedge aclk); c++; end while (rvalid !== 1'h1 && c < 100);
		tmo(c);
		rv = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg_%h", a), e & m, rv & m);
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rc(`UHB_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
		rc(`UHB_OFF_CIEN_SET, 32'hFF, 32'h0);
		wr(`UHB_OFF_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			link_speed <= uhb_speed_type'(i[1:0]);
			link_connected <= (i < 4);
			rc(`UHB_OFF_LINK, 32'h3, (i < 4) ? i : 0);
		end
		link_connected <= 1'h1;
		// lane 0 not strobed: control write ignored
		wstrb <= 4'hE;
		wr(`UHB_OFF_CTRL, 32'h0);
		wstrb <= 4'hF;
		rc(`UHB_OFF_CTRL, 32'hFF, 32'h1);
		// unmapped and misaligned places
		wr(8'h30, 32'h1);
		chk("wresp", 32'h2, 32'(resp));
		for (int i = 0; i < 2; i++) begin
			rd(i ? 8'h2C : 8'h06);
			chk("rresp", 32'h2, 32'(resp));
		end
		for (int i = 0; i < 3; i++) begin
			rnd = xs(rnd);
			wr(`UHB_OFF_CIEN_SET, rnd);
			cm = cm | rnd[7:0];
			wr(`UHB_OFF_EIEN_SET, rnd >> 8);
			em = em | rnd[11:8];
			rc(`UHB_OFF_CIEN_SET, 32'hFF, cm);
			rc(`UHB_OFF_EIEN_SET, 32'hF, em);
			wr(`UHB_OFF_CIEN_CLR, rnd >> 16);
			cm = cm & ~rnd[23:16];
			wr(`UHB_OFF_EIEN_CLR, rnd >> 24);
			em = em & ~rnd[27:24];
			rc(`UHB_OFF_CIEN_SET, 32'hFF, cm);
			rc(`UHB_OFF_EIEN_SET, 32'hF, em);
		end
		wr(`UHB_OFF_CIEN_CLR, 32'hFFFFFFFF);
		wr(`UHB_OFF_EIEN_CLR, 32'hFFFFFFFF);
		// power fault on, then off
		wr(`UHB_OFF_CIEN_SET, 32'h1);
		wr(`UHB_OFF_CTRL, 32'h3);
		power_fault_input_n <= 1'h0;
		repeat (6) @(posedge aclk);
		power_fault_input_n <= 1'h1;
		#1 chk("irq", 32'h1, 32'(irq));
		repeat (4) @(posedge aclk);
		rc(`UHB_OFF_CSTAT, 32'h1, 32'h1);
		rc(`UHB_OFF_CSTAT, 32'h1, 32'h0);
		@(posedge aclk);
		#1 chk("irq", 32'h0, 32'(irq));
		wr(`UHB_OFF_CTRL, 32'h1);
		power_fault_input_n <= 1'h0;
		repeat (6) @(posedge aclk);
		power_fault_input_n <= 1'h1;
		rc(`UHB_OFF_CSTAT, 32'h1, 32'h0);
		// link events into control status
		rnd = xs(rnd);
		link_ctrl_evt <= rnd[6:0] | 7'h01;
		@(posedge aclk);
		link_ctrl_evt <= 7'h00;
		rc(`UHB_OFF_CSTAT, 32'hFE, {rnd[6:0] | 7'h01, 1'h0});
		rc(`UHB_OFF_CSTAT, 32'hFE, 32'h0);
		// IN transfers with a varying device lag
		for (int ep = 1; ep < 4; ep++) begin
			rnd = xs(rnd);
			seed <= rnd;
			lag <= {5'h00, rnd[2:0]};
			n = dma_n;
			wr(`UHB_OFF_IN_REQ, 32'h1 << ep);
			k = 0;
			do begin @(posedge aclk); k++; end while (dma_n == n && k < 100);
			tmo(k);
			chk("dma_ep", ep, 32'(dma_e));
			chk("dma_data", exp_data(ep[3:0]), dma_w);
			rc(`UHB_OFF_EP_DATA, 32'hFFFFFFFF, exp_data(ep[3:0]));
			rc(`UHB_OFF_ESTAT, 32'hF, 32'h1 << ep);
			rc(`UHB_OFF_ESTAT, 32'hF, 32'h0);
		end
		// status IN on endpoint zero
		wr(`UHB_OFF_EIEN_SET, 32'h1);
		wr(`UHB_OFF_CTRL, 32'h21);
		k = 0;
		do begin @(posedge aclk); k++; end while (irq !== 1'h1 && k < 100);
		tmo(k);
		chk("tok_status", 32'h1, 32'(seen_st));
		chk("tok_ep", 32'h0, 32'(seen_ep));
		rc(`UHB_OFF_CTRL, 32'h20, 32'h0);
		rc(`UHB_OFF_CSTAT, 32'h1, 32'h0);
		rc(`UHB_OFF_ESTAT, 32'h1, 32'h1);
		@(posedge aclk);
		#1 chk("irq", 32'h0, 32'(irq));
		// cancel while the device stalls
		lag <= 8'hC8;
		n = dma_n;
		wr(`UHB_OFF_IN_REQ, 32'h4);
		wr(`UHB_OFF_IN_CLR, 32'h4);
		rc(`UHB_OFF_IN_REQ, 32'hF, 32'h0);
		chk("tok_valid", 32'h0, 32'(in_tok_valid));
		repeat (250) @(posedge aclk);
		chk("dma_count", n, dma_n);
		// bus signalling
		wr(`UHB_OFF_CTRL, 32'h5);
		#1 chk("bus_reset", 32'h1, 32'(bus_reset));
		rc(`UHB_OFF_LINK, 32'h10, 32'h0);
		repeat (20) @(posedge aclk);
		rc(`UHB_OFF_LINK, 32'h10, 32'h10);
		chk("bus_reset", 32'h1, 32'(bus_reset));
		wr(`UHB_OFF_CTRL, 32'h1);
		#1 chk("bus_reset", 32'h0, 32'(bus_reset));
		n = rend_n;
		wr(`UHB_OFF_CTRL, 32'h9);
		#1 chk("bus_resume", 32'h1, 32'(bus_resume));
		repeat (20) @(posedge aclk);
		rc(`UHB_OFF_LINK, 32'h10, 32'h10);
		wr(`UHB_OFF_CTRL, 32'h1);
		@(posedge aclk);
		#1 chk("resume_end", n + 1, rend_n);
		// device mode resume held inside its window
		wr(`UHB_OFF_CTRL, 32'h8);
		repeat (9) @(posedge aclk);
		rc(`UHB_OFF_LINK, 32'h30, 32'h10);
		wr(`UHB_OFF_CTRL, 32'h0);
		chk("resume_end", n + 1, rend_n);
		wr(`UHB_OFF_CTRL, 32'h11);
		#1 chk("bus_suspend", 32'h1, 32'(bus_suspend));
		wr(`UHB_OFF_CTRL, 32'h0);
		#1 chk("bus_suspend", 32'h0, 32'(bus_suspend));
		final_report();
	end
endmodule
